// File: ivr_irq_vector_relocation.sv
// Interrupt vector relocation control with AXI4-Lite register access.
// What this block does
// [R01] Select zero: vectors at flash start.
// [R02] Select one: vectors at boot section start.
// [R03] Boot start follows the boot size fuses.
// [R04] Boot reset fuse: reset vector at boot start.
// [R05] Software arms, then writes select within four.
// [R06] Select changes only while arm is set.
// [R07] Block interrupts from arm until next instruction.
// [R08] Without select write, block lasts four cycles.
// [R09] Blocking leaves the global enable flag alone.
// [R10] Arm clears after four cycles or select write.
// [R11] Boot vectors plus app lock: block in application.
// [R12] App vectors plus boot lock: block in boot.
// [R13] Bits 7,6 irq enables, 1 select, 0 arm.
// [R14] Bits 5 to 2 read zero, ignore writes.
// [R15] Windows count system clocks from the arm write.
`timescale 1ns/100ps
module ivr_irq_vector_relocation (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  input  wire logic [ivr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ivr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire ivr_pkg::ivr_fuse_t        fuse_pins,
  input  wire logic                      exec_in_boot,
  input  wire logic                      instr_done,
  output logic [ivr_pkg::FA_W-1:0]       vector_base_addr,
  output logic [ivr_pkg::FA_W-1:0]       reset_vector_addr,
  output logic                           irq_block,
  output logic                           ext_irq0_enable,
  output logic                           ext_irq1_enable
);
  import ivr_pkg::*;

  ivr_ctrl_t               ctrl_r;
  ivr_state_t              state_r;
  ivr_state_t              state_nxt;
  ivr_fuse_t               fs1_r;
  ivr_fuse_t               fs2_r;
  ivr_fuse_t               fs3_r;
  ivr_fuse_t               fuse_r;
  logic [CNT_W-1:0]        arm_cnt_r;
  logic                    irq_block_r;
  logic                    irq_block_nxt;
  logic [FA_W-1:0]         vec_base_r;
  logic [FA_W-1:0]         rst_vec_r;
  logic                    aw_hold_r;
  logic [ADDR_W-1:0]       awaddr_r;
  logic                    w_hold_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic                    bvalid_r;
  logic [1:0]              bresp_r;
  logic                    rvalid_r;
  logic [1:0]              rresp_r;
  logic [31:0]             rdata_r;
  logic                    aw_ok;
  logic                    w_ok;
  logic                    wr_fire;
  logic [ADDR_W-1:0]       wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic                    ctrl_wr;
  logic                    arm_wr;
  logic                    sel_wr;
  logic                    arm_expire;
  logic                    lock_hit;
  logic [31:0]             stat_word;

  // ----------------------------------------------------------------
  // Fuse synchroniser
  // ----------------------------------------------------------------

  // Three stages; a new fuse level is taken once stages two and three agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fs1_r  <= '0;
      fs2_r  <= '0;
      fs3_r  <= '0;
      fuse_r <= '0;
    end else if (ce) begin
      fs1_r <= fuse_pins;
      fs2_r <= fs1_r;
      fs3_r <= fs2_r;
      if (fs2_r == fs3_r) begin
        fuse_r <= fs3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------

  // Address and data are accepted in either order and held until both are in.
  assign s_axi_awready = ce & ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ce & ~w_hold_r & ~bvalid_r;
  assign aw_ok   = aw_hold_r | (s_axi_awvalid & s_axi_awready);
  assign w_ok    = w_hold_r | (s_axi_wvalid & s_axi_wready);
  assign wr_fire = ce & aw_ok & w_ok & ~bvalid_r;
  assign wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_hold_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;
  assign ctrl_wr = wr_fire & (wr_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) & wr_strb[0];

  // Holding registers for a half-arrived write and the write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= '0;
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (wr_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2] ||
                      wr_addr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_r <= 1'b1;
          awaddr_r  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_r <= 1'b1;
          wdata_r  <= s_axi_wdata;
          wstrb_r  <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ----------------------------------------------------------------
  // Control register and arm window
  // ----------------------------------------------------------------

  // [R05] [R06] An arm write opens the window; only a disarming write moves select.
  assign arm_wr     = ctrl_wr & wr_data[ARM_BIT];
  assign sel_wr     = ctrl_wr & ~wr_data[ARM_BIT] & ctrl_r.vector_change_arm;
  // [R15] Window counted in system clocks from the arm write.
  assign arm_expire = ctrl_r.vector_change_arm & (arm_cnt_r == ARM_WINDOW_CYC - 3'h1);

  // [R13] [R14] Enables always writable; reserved bits stay zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ivr_ctrl_t'(CTRL_RST);
    end else if (ce) begin
      if (ctrl_wr) begin
        ctrl_r.ext_irq1_enable <= wr_data[7];
        ctrl_r.ext_irq0_enable <= wr_data[6];
      end
      if (arm_wr) begin
        ctrl_r.vector_change_arm <= 1'b1;
      end else if (sel_wr) begin
        // [R10] Select write clears the arm at once.
        ctrl_r.vector_base_select <= wr_data[SEL_BIT];
        ctrl_r.vector_change_arm  <= 1'b0;
      end else if (arm_expire) begin
        // [R10] Hardware clear after four cycles.
        ctrl_r.vector_change_arm <= 1'b0;
      end
    end
  end

  // Counts the cycles the arm bit has been standing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_cnt_r <= '0;
    end else if (ce) begin
      if (arm_wr) begin
        arm_cnt_r <= '0;
      end else if (ctrl_r.vector_change_arm) begin
        arm_cnt_r <= arm_cnt_r + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt blocking
  // ----------------------------------------------------------------

  // [R07] [R08] Sequence: armed, then one instruction after the select write.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (arm_wr) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (arm_wr) begin
          state_nxt = ST_ARMED;
        end else if (sel_wr) begin
          state_nxt = ST_POST;
        end else if (arm_expire) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_POST: begin
        if (arm_wr) begin
          state_nxt = ST_ARMED;
        end else if (instr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Sequence state register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // [R11] [R12] Lock bits block interrupts in the section without the table.
  assign lock_hit = ctrl_r.vector_base_select ? (fuse_r.app_section_lock & ~exec_in_boot)
                                              : (fuse_r.boot_section_lock & exec_in_boot);
  // [R09] Separate suppress line; the core's global enable flag is never touched.
  assign irq_block_nxt = (state_nxt != ST_IDLE) | lock_hit;

  // Registered suppress output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_block_r <= 1'b0;
    end else if (ce) begin
      irq_block_r <= irq_block_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------

  // [R01] [R02] [R03] [R04] Table base and reset vector from select and fuses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_base_r <= APP_VEC_BASE;
      rst_vec_r  <= APP_VEC_BASE;
    end else if (ce) begin
      vec_base_r <= ctrl_r.vector_base_select ? boot_start_of(fuse_r.boot_size_fuses) : APP_VEC_BASE;
      rst_vec_r  <= fuse_r.boot_reset_fuse ? boot_start_of(fuse_r.boot_size_fuses) : APP_VEC_BASE;
    end
  end

  assign vector_base_addr  = vec_base_r;
  assign reset_vector_addr = rst_vec_r;
  assign irq_block         = irq_block_r;
  assign ext_irq0_enable   = ctrl_r.ext_irq0_enable;
  assign ext_irq1_enable   = ctrl_r.ext_irq1_enable;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------

  // Status word: suppress, sequence state, arm count and table base.
  assign stat_word = {8'h0, vec_base_r, 4'h0, 1'b0, arm_cnt_r, 2'(state_r), lock_hit, irq_block_r};
  assign s_axi_arready = ce & ~rvalid_r;

  // One read in flight; data and response held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_r <= 1'b1;
        rresp_r  <= RESP_OKAY;
        if (s_axi_araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) begin
          rdata_r <= {24'h0, ctrl_r};
        end else if (s_axi_araddr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]) begin
          rdata_r <= stat_word;
        end else begin
          rdata_r <= 32'h0;
          rresp_r <= RESP_SLVERR;
        end
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // [R06] Select guard.
  a_sel_guarded: assert property (!ctrl_r.vector_change_arm |=> $stable(ctrl_r.vector_base_select)) // [R06]
    else $error("Select changed without the arm open.");
  // [R10] Arm lifetime.
  a_arm_bounded: assert property (ctrl_r.vector_change_arm |-> arm_cnt_r < ARM_WINDOW_CYC) // [R10]
    else $error("Arm count ran past the window.");
  // [R10] Arm timeout.
  a_arm_timeout: assert property (ce && !arm_wr && !sel_wr && ctrl_r.vector_change_arm && arm_cnt_r == 3'h3 // [R10]
    |=> !ctrl_r.vector_change_arm && state_r == ST_IDLE) // [R08]
    else $error("Arm did not expire after four cycles.");
  // [R10] Select clears arm.
  a_sel_clears: assert property (sel_wr |=> !ctrl_r.vector_change_arm ##0 state_r == ST_POST) // [R10]
    else $error("Select write left the arm set.");
  // [R07] Block while armed.
  a_block_armed: assert property (state_r != ST_IDLE |-> irq_block) // [R07]
    else $error("Interrupts not blocked during the sequence.");
  // [R07] Post-write hold.
  a_post_hold: assert property (state_r == ST_POST && !(ce && (instr_done || arm_wr)) // [R07]
    |=> state_r == ST_POST)
    else $error("Block released before the next instruction.");
  // [R11] Application lock.
  a_app_lock: assert property (ce && ctrl_r.vector_base_select && !ctrl_wr && fuse_r.app_section_lock // [R11]
    && !exec_in_boot |=> irq_block_r)
    else $error("Application code not blocked under boot vectors.");
  // [R12] Boot lock.
  a_boot_lock: assert property (ce && !ctrl_r.vector_base_select && !ctrl_wr && fuse_r.boot_section_lock // [R12]
    && exec_in_boot |=> irq_block_r)
    else $error("Boot code not blocked under application vectors.");
  // [R01] Flash start base.
  a_app_base: assert property (ce && !ctrl_r.vector_base_select |=> vector_base_addr == APP_VEC_BASE) // [R01]
    else $error("Vector base not at flash start.");
  // [R03] Boot start base.
  a_boot_base: assert property (ce && ctrl_r.vector_base_select // [R03]
    |=> vector_base_addr == boot_start_of($past(fuse_r.boot_size_fuses))) // [R02]
    else $error("Vector base not at boot section start.");
  // [R14] Reserved bits.
  a_rsvd_zero: assert property (ctrl_r.rsvd == 4'h0) // [R14]
    else $error("Reserved control bits not zero.");

  c_relocate: cover property (arm_wr ##[1:3] sel_wr ##[1:16] state_r == ST_IDLE);
  c_timeout: cover property (arm_wr ##1 (!sel_wr && !arm_wr) [*4] ##1 state_r == ST_IDLE);
  c_lock_block: cover property (lock_hit && state_r == ST_IDLE ##1 irq_block_r);
  c_ctrl_read: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_OFS);

endmodule : ivr_irq_vector_relocation

// File: ivr_pkg.sv
// Shared constants and types for the interrupt vector relocation block.
package ivr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0]  CTRL_OFS = 4'h0;  // general_irq_ctrl
  localparam logic [3:0]  STAT_OFS = 4'h4;  // Sequence and lock status.
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam int unsigned SEL_BIT  = 1;
  localparam int unsigned ARM_BIT  = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing and flash layout
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W          = 3;
  localparam logic [2:0]  ARM_WINDOW_CYC = 3'h4;  // Arm window in system clock cycles.
  localparam int unsigned FA_W           = 12;    // Flash word address width.
  localparam logic [11:0] APP_VEC_BASE   = 12'h000;
  localparam logic [11:0] BOOT_START_2K  = 12'hc00;
  localparam logic [11:0] BOOT_START_1K  = 12'he00;
  localparam logic [11:0] BOOT_START_512 = 12'hf00;
  localparam logic [11:0] BOOT_START_256 = 12'hf80;
  localparam logic [1:0]  FUSE_RST       = 2'h0;

  // Control register layout.
  typedef struct packed {
    logic       ext_irq1_enable;
    logic       ext_irq0_enable;
    logic [3:0] rsvd;
    logic       vector_base_select;
    logic       vector_change_arm;
  } ivr_ctrl_t;

  // Fuse and lock-bit levels as they arrive from the fuse array.
  typedef struct packed {
    logic       boot_reset_fuse;
    logic [1:0] boot_size_fuses;
    logic       app_section_lock;
    logic       boot_section_lock;
  } ivr_fuse_t;

  // Relocation sequence states.
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_POST} ivr_state_t;

  // Start of the boot section for each boot size setting.
  function automatic logic [11:0] boot_start_of(input logic [1:0] size);
    logic [11:0] a;
    a = BOOT_START_2K;
    case (size)
      2'h0:    a = BOOT_START_2K;
      2'h1:    a = BOOT_START_1K;
      2'h2:    a = BOOT_START_512;
      default: a = BOOT_START_256;
    endcase
    return a;
  endfunction : boot_start_of

endpackage : ivr_pkg

// File: test_irq_vector_relocation.sv
// Self-checking testbench for the interrupt vector relocation block.
`timescale 1ns/100ps
module test_irq_vector_relocation;
  import ivr_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus rows and signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
    logic [1:0]  resp;
    logic [7:0]  ctrl;
  } ivr_row_t;

  // Address, write data, strobes, expected response, expected ctrl readback.
  ivr_row_t    rows [6] = '{
    '{4'h0, 32'h0000_00c0, 4'hf, RESP_OKAY, 8'hc0},
    '{4'h0, 32'h0000_003c, 4'hf, RESP_OKAY, 8'h00},
    '{4'h0, 32'h0000_0042, 4'hf, RESP_OKAY, 8'h40},
    '{4'h0, 32'h0000_0081, 4'h0, RESP_OKAY, 8'h40},
    '{4'h8, 32'h0000_0080, 4'hf, RESP_SLVERR, 8'h40},
    '{4'h4, 32'h0000_00ff, 4'hf, RESP_OKAY, 8'h40}};
  logic [11:0] starts [4] = '{BOOT_START_2K, BOOT_START_1K, BOOT_START_512, BOOT_START_256};

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] awaddr = 4'h0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        wstrb = 4'h0;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b1;  // Response ready is held high throughout.
  logic [ADDR_W-1:0] araddr = 4'h0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b1;  // Read ready is held high throughout.
  ivr_fuse_t         fuse_pins = 5'h10;
  logic              exec_in_boot = 1'b0;
  logic              instr_done = 1'b0;
  logic [FA_W-1:0]   vector_base_addr;
  logic [FA_W-1:0]   reset_vector_addr;
  logic              irq_block;
  logic              ext_irq0_enable;
  logic              ext_irq1_enable;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  int                cyc_count = 0;
  int                blk_cnt = 0;
  logic [31:0]       d;
  logic [1:0]        r;

  ivr_irq_vector_relocation u_dut (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .ce                (ce),
    .s_axi_awaddr      (awaddr),
    .s_axi_awvalid     (awvalid),
    .s_axi_awready     (awready),
    .s_axi_wdata       (wdata),
    .s_axi_wstrb       (wstrb),
    .s_axi_wvalid      (wvalid),
    .s_axi_wready      (wready),
    .s_axi_bresp       (bresp),
    .s_axi_bvalid      (bvalid),
    .s_axi_bready      (bready),
    .s_axi_araddr      (araddr),
    .s_axi_arvalid     (arvalid),
    .s_axi_arready     (arready),
    .s_axi_rdata       (rdata),
    .s_axi_rresp       (rresp),
    .s_axi_rvalid      (rvalid),
    .s_axi_rready      (rready),
    .fuse_pins         (fuse_pins),
    .exec_in_boot      (exec_in_boot),
    .instr_done        (instr_done),
    .vector_base_addr  (vector_base_addr),
    .reset_vector_addr (reset_vector_addr),
    .irq_block         (irq_block),
    .ext_irq0_enable   (ext_irq0_enable),
    .ext_irq1_enable   (ext_irq1_enable)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and blocking monitor
  // ----------------------------------------------------------------
  // The clock toggles every 4 ns, for a period of 8 ns.
  always #4 aclk = ~aclk;

  // A hang ends the run as a failure.
  always @(posedge aclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Counts cycles with interrupts held off, sampled mid-cycle.
  always @(negedge aclk) begin
    if (irq_block === 1'b1) begin
      blk_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // Compares a seen value with the expected one.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One write; call right after a rising edge, returns right after one.
  task automatic wr(input logic [3:0] a, input logic [31:0] dat, input logic [3:0] s, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    b_ok = 1'b0;
    resp = 2'h3;
    awaddr <= a;
    wdata <= dat;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
  endtask : wr

  // One read; same edge convention as the write task.
  task automatic rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic ar_ok;
    logic r_ok;
    r_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      dat = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
  endtask : rd

  // Applies fuse levels and execution region, then checks the block level.
  task automatic probe(input logic [4:0] f, input logic e, input logic exp);
    fuse_pins <= f;
    exec_in_boot <= e;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk("lock block", irq_block, exp);
    @(posedge aclk);
  endtask : probe

  // Arms, writes the select value at once, then retires one instruction.
  task automatic relocate(input logic sel);
    wr(CTRL_OFS, 32'h1, 4'hf, r);
    wr(CTRL_OFS, {30'h0, sel, 1'b0}, 4'hf, r);
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk("block until instruction", irq_block, 1'b1);
    @(posedge aclk);
    instr_done <= 1'b1;
    @(posedge aclk);
    instr_done <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("block released", irq_block, 1'b0);
    @(posedge aclk);
  endtask : relocate

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("reset block", irq_block, 1'b0);
    chk("reset vectors", vector_base_addr, APP_VEC_BASE);
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data, rows[i].strb, r);
      chk("bresp", r, rows[i].resp);
      rd(CTRL_OFS, d, r);
      chk("ctrl", d, {24'h0, rows[i].ctrl});
      chk("enables", {ext_irq1_enable, ext_irq0_enable}, rows[i].ctrl[7:6]);
    end
    rd(4'h8, d, r);
    chk("unmapped rresp", r, RESP_SLVERR);
    chk("unmapped rdata", d, 32'h0);
    // Arm alone: four blocked cycles, arm drops, a late select is ignored.
    blk_cnt = 0;
    wr(CTRL_OFS, 32'h1, 4'hf, r);
    repeat (10) @(posedge aclk);
    chk("blocked cycles", blk_cnt, 4);
    rd(CTRL_OFS, d, r);
    chk("arm self clear", d, 32'h0);
    wr(CTRL_OFS, 32'h2, 4'hf, r);
    rd(CTRL_OFS, d, r);
    chk("late select", d, 32'h0);
    // Full relocation to the boot section.
    relocate(1'b1);
    rd(CTRL_OFS, d, r);
    chk("select set", d, 32'h2);
    for (int k = 0; k < 4; k++) begin
      fuse_pins <= {1'b1, k[1:0], 2'b00};
      repeat (8) @(posedge aclk);
      @(negedge aclk);
      chk("boot vector base", vector_base_addr, starts[k]);
      chk("boot reset vector", reset_vector_addr, starts[k]);
      @(posedge aclk);
    end
    probe(5'h02, 1'b0, 1'b1);
    probe(5'h02, 1'b1, 1'b0);
    probe(5'h01, 1'b1, 1'b0);
    probe(5'h00, 1'b0, 1'b0);
    relocate(1'b0);
    chk("app vector base", vector_base_addr, APP_VEC_BASE);
    chk("no boot reset", reset_vector_addr, APP_VEC_BASE);
    probe(5'h01, 1'b1, 1'b1);
    probe(5'h01, 1'b0, 1'b0);
    probe(5'h02, 1'b0, 1'b0);
    // Clock enable low refuses bus requests.
    ce <= 1'b0;
    @(negedge aclk);
    chk("frozen awready", awready, 1'b0);
    chk("frozen arready", arready, 1'b0);
    @(posedge aclk);
    ce <= 1'b1;
    // Reset in mid-run returns the register to zero.
    wr(CTRL_OFS, 32'hc0, 4'hf, r);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("mid reset enables", {ext_irq1_enable, ext_irq0_enable}, 2'b00);
    @(posedge aclk);
    rd(CTRL_OFS, d, r);
    chk("mid reset ctrl", d, {24'h0, CTRL_RST});
    conclude();
  end

endmodule : test_irq_vector_relocation
